/* File: src/exec_timing_cfg.svh */
// constants for the instruction execution and timing core
`ifndef EXEC_TIMING_CFG_SVH
`define EXEC_TIMING_CFG_SVH
`define CLK_PER_ICYCLE 2'h3
`define PHASE_FETCH 2'h0
`define PHASE_EXEC 2'h3
`define PC_W 11
`define PC_RESET 11'h000
`define STACK_DEPTH 4
`define SP_W 2
`define DM_AW 7
`define DM_DEPTH 128
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define OPC_W 5
`define TBL_HI_RESET 6'h00
`define OP_HI 13
`define OP_LO 9
`define TO_MEM_BIT 8
`define BIT_HI 6
`define BIT_LO 4
`define IMM_HI 7
`define PCL_W 8
`endif

/* File: src/exec_timing_pkg.sv */
// types for the instruction execution and timing core
package exec_timing_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_MOV_A_M = 5'h01, OP_MOV_M_A = 5'h02, OP_MOV_A_X = 5'h03,
        OP_ADD = 5'h04, OP_SUB = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
        OP_XOR = 5'h08, OP_INVERT = 5'h09, OP_INC = 5'h0A, OP_DEC = 5'h0B,
        OP_RR = 5'h0C, OP_RL = 5'h0D, OP_RRC = 5'h0E, OP_RLC = 5'h0F,
        OP_BIT_SET = 5'h10, OP_BIT_CLR = 5'h11, OP_SKIP_ZERO = 5'h12, OP_SKIP_BIT_SET = 5'h13,
        OP_SKIP_BIT_CLR = 5'h14, OP_JUMP = 5'h15, OP_CALL = 5'h16, OP_RET = 5'h17,
        OP_INTERRUPT_EXIT = 5'h18, OP_TABLE_READ = 5'h19, OP_WRITE_PCL = 5'h1A
    } op_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLUSH = 2'b01
    } seq_state_t;
endpackage

/* File: src/exec_timing_core.sv */
// instruction sequencer and data path of the 8-bit core
`timescale 1ns/1ps
`include "exec_timing_cfg.svh"

module exec_timing_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // program memory: word at prog_addr arrives on prog_data
    output logic [`PC_W-1:0] prog_addr,
    input wire logic [13:0] prog_data,
    // status
    output logic [7:0] acc_out,
    output logic zero_flag,
    output logic carry_flag,
    output logic [1:0] phase_out,
    output logic icycle_strobe,
    output logic table_valid,
    output logic [7:0] table_data
);
    //////////////////////////////////////////////////////////////////////
    // word fields; the bit select overlaps the top address bits, which ties the bit to the byte
    wire exec_timing_pkg::op_t op_w = exec_timing_pkg::op_t'(prog_data[`OP_HI:`OP_LO]);
    wire logic to_mem_w = prog_data[`TO_MEM_BIT];
    wire logic [`DM_AW-1:0] m_addr_w = prog_data[`DM_AW-1:0];
    wire logic [2:0] bit_sel_w = prog_data[`BIT_HI:`BIT_LO];
    wire logic [7:0] imm_w = prog_data[`IMM_HI:0];

    logic [1:0] phase_q;
    logic [`PC_W-1:0] pc_q;
    logic [7:0] acc_q;
    logic zero_q;
    logic carry_q;
    exec_timing_pkg::seq_state_t state_q;
    logic [`PC_W-1:0] stack_q [`STACK_DEPTH];
    logic [`SP_W-1:0] sp_q;
    logic [7:0] dmem_q [`DM_DEPTH];
    logic [`PC_W-1:0] pc_d;
    logic tbl_valid_q;
    logic [7:0] tbl_data_q;
    logic strobe_q;
    logic tbl_pending_q;

    //////////////////////////////////////////////////////////////////////
    // clock divider: one instruction cycle is four ref_clk periods
    // divide by four
    wire logic exec_w = (phase_q == `PHASE_EXEC);
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase_q <= `PHASE_FETCH;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // operand decode; bit-test memory byte read combinationally
    wire logic [7:0] mem_w = dmem_q[m_addr_w];
    wire logic [7:0] bit_mask_w = `BYTE_ONE << bit_sel_w;
    wire logic run_w = (state_q == exec_timing_pkg::ST_RUN);
    wire logic [8:0] add_w = {1'b0, acc_q} + {1'b0, mem_w};
    wire logic [8:0] sub_w = {1'b0, acc_q} - {1'b0, mem_w};

    // skip decision from byte or bit test
    wire logic skip_w = (op_w == exec_timing_pkg::OP_SKIP_ZERO && mem_w == `BYTE_ZERO)
        || (op_w == exec_timing_pkg::OP_SKIP_BIT_SET && (mem_w & bit_mask_w) != `BYTE_ZERO)
        || (op_w == exec_timing_pkg::OP_SKIP_BIT_CLR && (mem_w & bit_mask_w) == `BYTE_ZERO);

    wire logic two_cycle_w = (op_w == exec_timing_pkg::OP_JUMP) || (op_w == exec_timing_pkg::OP_CALL)
        || (op_w == exec_timing_pkg::OP_TABLE_READ)
        || (op_w == exec_timing_pkg::OP_RET) || (op_w == exec_timing_pkg::OP_INTERRUPT_EXIT)
        // low pc byte write is a jump
        || (op_w == exec_timing_pkg::OP_WRITE_PCL)
        || skip_w;

    //////////////////////////////////////////////////////////////////////
    // alu result for register-style ops
    logic [7:0] res_w;
    logic res_zero_en_w;
    logic res_carry_en_w;
    logic res_carry_w;
    logic res_write_w;
    always_comb begin
        res_w = acc_q;
        res_zero_en_w = 1'b0;
        res_carry_en_w = 1'b0;
        res_carry_w = carry_q;
        res_write_w = 1'b0;
        case (op_w)
            exec_timing_pkg::OP_MOV_A_M: res_w = mem_w;
            exec_timing_pkg::OP_MOV_M_A: begin
                res_w = acc_q;
                res_write_w = 1'b1;
            end
            exec_timing_pkg::OP_MOV_A_X: res_w = imm_w;
            exec_timing_pkg::OP_ADD: begin
                res_w = add_w[7:0];
                res_zero_en_w = 1'b1;
                res_carry_en_w = 1'b1;
                res_carry_w = add_w[8];
            end
            exec_timing_pkg::OP_SUB: begin
                res_w = sub_w[7:0];
                res_zero_en_w = 1'b1;
                res_carry_en_w = 1'b1;
                res_carry_w = sub_w[8];
            end
            exec_timing_pkg::OP_AND: begin
                res_w = acc_q & mem_w;
                res_zero_en_w = 1'b1;
            end
            exec_timing_pkg::OP_OR: begin
                res_w = acc_q | mem_w;
                res_zero_en_w = 1'b1;
            end
            exec_timing_pkg::OP_XOR: begin
                res_w = acc_q ^ mem_w;
                res_zero_en_w = 1'b1;
            end
            exec_timing_pkg::OP_INVERT: begin
                res_w = ~mem_w;
                res_zero_en_w = 1'b1;
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_INC: begin
                res_w = mem_w + `BYTE_ONE;
                res_zero_en_w = 1'b1;
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_DEC: begin
                res_w = mem_w - `BYTE_ONE;
                res_zero_en_w = 1'b1;
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_RR: begin
                res_w = {mem_w[0], mem_w[7:1]};
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_RL: begin
                res_w = {mem_w[6:0], mem_w[7]};
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_RRC: begin
                res_w = {carry_q, mem_w[7:1]};
                res_carry_en_w = 1'b1;
                res_carry_w = mem_w[0];
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_RLC: begin
                res_w = {mem_w[6:0], carry_q};
                res_carry_en_w = 1'b1;
                res_carry_w = mem_w[7];
                res_write_w = to_mem_w;
            end
            exec_timing_pkg::OP_BIT_SET: begin
                res_w = mem_w | bit_mask_w;
                res_write_w = 1'b1;
            end
            exec_timing_pkg::OP_BIT_CLR: begin
                res_w = mem_w & ~bit_mask_w;
                res_write_w = 1'b1;
            end
            default: res_w = acc_q;
        endcase
    end

    // only results landing in acc update it; memory writes leave acc alone
    wire logic acc_we_w = run_w && exec_w && !res_write_w
        && op_w inside {exec_timing_pkg::OP_MOV_A_M, exec_timing_pkg::OP_MOV_A_X, exec_timing_pkg::OP_ADD,
        exec_timing_pkg::OP_SUB, exec_timing_pkg::OP_AND, exec_timing_pkg::OP_OR, exec_timing_pkg::OP_XOR,
        exec_timing_pkg::OP_INVERT, exec_timing_pkg::OP_INC, exec_timing_pkg::OP_DEC, exec_timing_pkg::OP_RR,
        exec_timing_pkg::OP_RL, exec_timing_pkg::OP_RRC, exec_timing_pkg::OP_RLC};
    wire logic mem_we_w = run_w && exec_w && res_write_w;
    wire logic [`PC_W-1:0] pc_next_w = pc_q + `PC_W'(1);
    wire logic [`PC_W-1:0] pc_skip_w = pc_q + `PC_W'(2);

    //////////////////////////////////////////////////////////////////////
    // next program counter
    always_comb begin
        pc_d = pc_next_w;
        if (!run_w) begin
            pc_d = pc_q;
        end else if (op_w == exec_timing_pkg::OP_JUMP || op_w == exec_timing_pkg::OP_CALL) begin
            pc_d = prog_data[`PC_W-1:0];
        end else if (op_w == exec_timing_pkg::OP_RET || op_w == exec_timing_pkg::OP_INTERRUPT_EXIT) begin
            pc_d = stack_q[sp_q - `SP_W'(1)];
        end else if (op_w == exec_timing_pkg::OP_WRITE_PCL) begin
            pc_d = {pc_q[`PC_W-1:`PCL_W], acc_q};
        end else if (skip_w) begin
            pc_d = pc_skip_w;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // sequencer: the flush cycle is the second instruction cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q <= exec_timing_pkg::ST_RUN;
            pc_q <= `PC_RESET;
        end else if (exec_w) begin
            state_q <= (run_w && two_cycle_w) ? exec_timing_pkg::ST_FLUSH : exec_timing_pkg::ST_RUN;
            // the flush cycle holds pc, so a branch target is never stepped over
            pc_q <= pc_d;
        end
    end

    // return stack holds address after call
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sp_q <= `SP_W'(0);
        end else if (exec_w && run_w && op_w == exec_timing_pkg::OP_CALL) begin
            stack_q[sp_q] <= pc_next_w;
            sp_q <= sp_q + `SP_W'(1);
        end else if (exec_w && run_w && (op_w == exec_timing_pkg::OP_RET || op_w == exec_timing_pkg::OP_INTERRUPT_EXIT)) begin
            sp_q <= sp_q - `SP_W'(1);
        end
    end

    // accumulator, flags and data memory
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            acc_q <= `BYTE_ZERO;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
        end else if (run_w && exec_w) begin
            if (acc_we_w) begin
                acc_q <= res_w;
            end
            if (res_zero_en_w) begin
                zero_q <= (res_w == `BYTE_ZERO);
            end
            if (res_carry_en_w) begin
                carry_q <= res_carry_w;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (mem_we_w) begin
            dmem_q[m_addr_w] <= res_w;
        end
    end

    // table word captured in flush cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tbl_valid_q <= 1'b0;
            tbl_data_q <= `BYTE_ZERO;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= exec_w;
            tbl_valid_q <= exec_w && !run_w && tbl_pending_q;
            if (exec_w && !run_w && tbl_pending_q) begin
                tbl_data_q <= prog_data[`IMM_HI:0];
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tbl_pending_q <= 1'b0;
        end else if (exec_w) begin
            tbl_pending_q <= run_w && op_w == exec_timing_pkg::OP_TABLE_READ;
        end
    end

    // fetch address: table cycle points at acc within the current pc page
    logic [`PC_W-1:0] addr_q;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_q <= `PC_RESET;
        end else if (exec_w) begin
            addr_q <= (run_w && op_w == exec_timing_pkg::OP_TABLE_READ) ? {pc_q[`PC_W-1:`PCL_W], acc_q} : pc_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs, all registered
    assign prog_addr = addr_q;
    assign acc_out = acc_q;
    assign zero_flag = zero_q;
    assign carry_flag = carry_q;
    assign phase_out = phase_q;
    assign icycle_strobe = strobe_q;
    assign table_valid = tbl_valid_q;
    assign table_data = tbl_data_q;

    //////////////////////////////////////////////////////////////////////
    // checks
    a_phase_wraps: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_w |=> phase_q == `PHASE_FETCH ##3 exec_w) else $error("phase not period four");
    a_jump_flush: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_JUMP) |=> !run_w [*4]) else $error("jump not two cycles");
    a_ret_flush: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_RET) |=> !run_w [*4]) else $error("return not two cycles");
    a_pcl_flush: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_WRITE_PCL) |=> pc_q[`PCL_W-1:0] == $past(acc_q) && !run_w)
        else $error("pcl write wrong");
    a_noskip_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_SKIP_ZERO && !skip_w) |=> run_w)
        else $error("untaken skip stalled");
    a_skip_target: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && skip_w) |=> pc_q == $past(pc_q) + `PC_W'(2)) else $error("skip target wrong");
    a_call_push: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_CALL) |=> sp_q == $past(sp_q) + `SP_W'(1))
        else $error("call did not push");
    a_jump_nopush: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_JUMP) |=> $stable(sp_q)) else $error("jump pushed");
    a_zero_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_AND) |=> zero_q == (acc_q == `BYTE_ZERO))
        else $error("zero flag wrong");
    a_table_valid: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (exec_w && run_w && op_w == exec_timing_pkg::OP_TABLE_READ) |=> ##4 table_valid) else $error("no table data");
    c_call: cover property (@(posedge ref_clk) exec_w && run_w && op_w == exec_timing_pkg::OP_CALL);
    c_skip: cover property (@(posedge ref_clk) exec_w && run_w && skip_w);
    c_table: cover property (@(posedge ref_clk) table_valid);
endmodule

/* File: tb/mcu_instruction_execution_timing_tb_top.sv */
// self-checking bench for the instruction execution and timing core
`timescale 1ns/1ps
`include "exec_timing_cfg.svh"

module mcu_instruction_execution_timing_tb_top;
    // expected state seen at one instruction-cycle strobe
    typedef struct {
        logic [10:0] pa;
        logic [7:0] a;
        logic z;
        logic c;
        bit chk_pa;
        logic tv;
        logic [7:0] td;
    } exp_t;

    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] prog_data = 14'h0000;
    logic [`PC_W-1:0] prog_addr;
    logic [7:0] acc_out;
    logic zero_flag;
    logic carry_flag;
    logic [1:0] phase_out;
    logic icycle_strobe;
    logic table_valid;
    logic [7:0] table_data;
    logic [13:0] rom [0:2047];
    logic [7:0] dmem [0:127];
    logic [10:0] stk [$];
    exp_t expq [$];
    logic [31:0] seed_state = 32'h63F660D5;
    logic [10:0] m_pc = 11'h000;
    logic [7:0] m_a = 8'h00;
    logic m_z = 1'b0;
    logic m_c = 1'b0;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int gap = 0;
    bit seen = 0;
    localparam logic [10:0] END_PC = 11'h2B3;

    exec_timing_core dut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .acc_out(acc_out),
        .zero_flag(zero_flag),
        .carry_flag(carry_flag),
        .phase_out(phase_out),
        .icycle_strobe(icycle_strobe),
        .table_valid(table_valid),
        .table_data(table_data)
    );

    always #4 ref_clk = ~ref_clk;

    // program memory answers a little after each edge, well before the next fetch
    always @(posedge ref_clk) begin
        #1;
        prog_data <= rom[prog_addr];
    end

    function automatic logic [31:0] next_rand();
        logic [31:0] x;
        x = seed_state;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        seed_state = x;
        return x;
    endfunction

    function automatic logic [13:0] wd(input logic [4:0] op, input logic [8:0] low);
        return {op, low};
    endfunction

    // branch targets overlap the low opcode bits, so they are chosen to agree with them
    function automatic logic [13:0] tg(input logic [4:0] op, input logic [10:0] t);
        return {op[4:2], t};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // program: fill data memory, random data ops, then a fixed control tail
    task automatic build_rom();
        logic [31:0] x;
        for (int i = 0; i < 2048; i++) rom[i] = 14'h0000;
        for (int i = 0; i < 128; i++) begin
            x = next_rand();
            rom[2*i] = wd(exec_timing_pkg::OP_MOV_A_X, {1'b0, (x[11:8] == 4'h0) ? 8'h00 : x[7:0]});
            rom[2*i+1] = wd(exec_timing_pkg::OP_MOV_M_A, {2'b00, i[6:0]});
        end
        // the word before the call stays a no-op, so a taken skip cannot hop over the call
        for (int i = 256; i < 639; i++) begin
            x = next_rand();
            rom[i] = wd(5'(x[31:16] % 21), x[8:0]);
        end
        rom[11'h280] = tg(exec_timing_pkg::OP_CALL, 11'h500);
        rom[11'h281] = wd(exec_timing_pkg::OP_MOV_A_X, 9'h0A0);
        rom[11'h282] = wd(exec_timing_pkg::OP_WRITE_PCL, 9'h000);
        rom[11'h283] = wd(exec_timing_pkg::OP_MOV_A_X, 9'h055);
        rom[11'h2A0] = tg(exec_timing_pkg::OP_JUMP, 11'h2B0);
        rom[11'h2A1] = wd(exec_timing_pkg::OP_MOV_A_X, 9'h066);
        rom[11'h2B0] = wd(exec_timing_pkg::OP_MOV_A_X, 9'h0F0);
        rom[11'h2B1] = wd(exec_timing_pkg::OP_TABLE_READ, 9'h000);
        rom[11'h2B2] = tg(exec_timing_pkg::OP_CALL, 11'h510);
        rom[END_PC] = tg(exec_timing_pkg::OP_JUMP, END_PC);
        rom[11'h500] = wd(exec_timing_pkg::OP_INC, 9'h005);
        rom[11'h501] = wd(exec_timing_pkg::OP_RET, 9'h000);
        rom[11'h510] = wd(exec_timing_pkg::OP_INTERRUPT_EXIT, 9'h000);
        x = next_rand();
        rom[11'h2F0] = x[13:0];
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reference model: one queue entry per instruction cycle
    task automatic run_model();
        logic [13:0] w;
        logic [4:0] op;
        logic [7:0] v;
        logic [7:0] r;
        logic [2:0] b;
        logic [10:0] nx;
        logic [10:0] ta;
        logic skp;
        exp_t e;
        for (int n = 0; n < 4000 && m_pc != END_PC; n++) begin
            w = rom[m_pc];
            op = w[13:9];
            v = dmem[w[6:0]];
            b = w[6:4];
            r = v;
            nx = m_pc + 11'h001;
            ta = {m_pc[10:8], m_a};
            skp = 1'b0;
            case (op)
                exec_timing_pkg::OP_ADD: {m_c, r} = {1'b0, m_a} + {1'b0, v};
                exec_timing_pkg::OP_SUB: {m_c, r} = {1'b0, m_a} - {1'b0, v};
                exec_timing_pkg::OP_AND: r = m_a & v;
                exec_timing_pkg::OP_OR: r = m_a | v;
                exec_timing_pkg::OP_XOR: r = m_a ^ v;
                exec_timing_pkg::OP_INVERT: r = ~v;
                exec_timing_pkg::OP_INC: r = v + 8'h01;
                exec_timing_pkg::OP_DEC: r = v - 8'h01;
                exec_timing_pkg::OP_RR: r = {v[0], v[7:1]};
                exec_timing_pkg::OP_RL: r = {v[6:0], v[7]};
                exec_timing_pkg::OP_RRC: {r, m_c} = {m_c, v};
                exec_timing_pkg::OP_RLC: {m_c, r} = {v, m_c};
                exec_timing_pkg::OP_MOV_A_M: m_a = v;
                exec_timing_pkg::OP_MOV_M_A: dmem[w[6:0]] = m_a;
                exec_timing_pkg::OP_MOV_A_X: m_a = w[7:0];
                exec_timing_pkg::OP_BIT_SET: dmem[w[6:0]][b] = 1'b1;
                exec_timing_pkg::OP_BIT_CLR: dmem[w[6:0]][b] = 1'b0;
                exec_timing_pkg::OP_SKIP_ZERO: skp = (v == 8'h00);
                exec_timing_pkg::OP_SKIP_BIT_SET: skp = v[b];
                exec_timing_pkg::OP_SKIP_BIT_CLR: skp = !v[b];
                exec_timing_pkg::OP_JUMP: nx = w[10:0];
                exec_timing_pkg::OP_CALL: begin
                    stk.push_back(nx);
                    nx = w[10:0];
                end
                exec_timing_pkg::OP_RET, exec_timing_pkg::OP_INTERRUPT_EXIT: nx = stk.pop_back();
                exec_timing_pkg::OP_WRITE_PCL: nx = {m_pc[10:8], m_a};
                default: ;
            endcase
            // only one-operand ops may write back; two-operand results always land in acc
            if (op inside {[5'h09:5'h0F]} && w[8]) dmem[w[6:0]] = r;
            if (op inside {[5'h04:5'h08]} || (op inside {[5'h09:5'h0F]} && !w[8])) m_a = r;
            if (op inside {[5'h04:5'h0B]}) m_z = (r == 8'h00);
            if (skp) nx = nx + 11'h001;
            e = '{ta, m_a, m_z, m_c, op == exec_timing_pkg::OP_TABLE_READ, 1'b0, 8'h00};
            if (skp || op inside {[5'h15:5'h1A]}) expq.push_back(e);
            e = '{nx, m_a, m_z, m_c, 1'b1, op == exec_timing_pkg::OP_TABLE_READ, rom[ta][7:0]};
            expq.push_back(e);
            m_pc = nx;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_pc(input string name, input logic [10:0] expv, input logic [10:0] gotv);
        samples_checked++;
        if (gotv !== expv) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, expv, gotv);
        end
    endtask

    task automatic cmp_byte(input string name, input logic [7:0] expv, input logic [7:0] gotv);
        samples_checked++;
        if (gotv !== expv) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, expv, gotv);
        end
    endtask

    task automatic cmp_bit(input string name, input logic expv, input logic gotv);
        samples_checked++;
        if (gotv !== expv) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", name, expv, gotv);
        end
    endtask

    task automatic check_cycle();
        exp_t e;
        e = expq.pop_front();
        if (seen) cmp_bit("strobe_gap", 1'b1, gap == 4);
        cmp_bit("phase_out", 1'b1, phase_out === 2'h0);
        gap = 0;
        seen = 1;
        if (e.chk_pa) cmp_pc("prog_addr", e.pa, prog_addr);
        cmp_byte("acc_out", e.a, acc_out);
        cmp_bit("zero_flag", e.z, zero_flag);
        cmp_bit("carry_flag", e.c, carry_flag);
        cmp_bit("table_valid", e.tv, table_valid);
        if (e.tv) cmp_byte("table_data", e.td, table_data);
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang is cut short well beyond the few thousand cycles the program needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        build_rom();
        run_model();
        repeat (4) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        while (expq.size() > 0) begin
            @(posedge ref_clk);
            #2;
            gap++;
            if (icycle_strobe === 1'b1) check_cycle();
            else cmp_bit("table_valid", 1'b0, table_valid);
        end
        report_and_stop();
    end
endmodule
